/* inc/mps_defines.svh */
// Constants for the multi-protocol serial block.
// Assumes a 10 MHz system clock.
`ifndef MPS_DEFINES_SVH
`define MPS_DEFINES_SVH
`define MPS_P_UART    2'h0
`define MPS_P_SPI     2'h1
`define MPS_P_I2C     2'h2
`define MPS_U_LIN     2'h1
`define MPS_U_IRDA    2'h2
`define MPS_U_SC      2'h3
`define MPS_S_FRAMED  2'h1
`define MPS_S_HALF    2'h2
`define MPS_W         9
`define MPS_DEPTH     8
`define MPS_MBX_WORDS 16
`define MPS_CLK_NS    100
`define MPS_UART_NS   1000
`define MPS_I2C_NS    2500
`define MPS_UART_CYC  16'((`MPS_UART_NS + `MPS_CLK_NS - 1) / `MPS_CLK_NS)
`define MPS_I2C_QCYC  16'((`MPS_I2C_NS / 4 + `MPS_CLK_NS - 1) / `MPS_CLK_NS)
`define MPS_IR_NUM    18'h3
`define MPS_IR_SH     4
`define MPS_LAST_BIT  4'h7
`define MPS_ACK_BIT   4'h8
`define MPS_UF_LONG   4'hb
`define MPS_UF_SHORT  4'ha
`define MPS_FILL      8'hff
`endif

/* inc/mps_pkg.sv */
// Types shared by the multi-protocol serial block.
// Assumes mps_defines.svh is included by the design files.
package mps_pkg;
    typedef enum logic [2:0] {
        m_idle, m_start, m_next, m_bit, m_stop
    } mps_m_e;
endpackage

/* core/mps_top.sv */
// Multi-protocol serial block: UART, SPI slave, I2C master/slave.
// Assumes pins arrive asynchronously and controls are static per frame.
`timescale 1ns/10ps
`include "mps_defines.svh"

module mps_fifo #(
    parameter int W = `MPS_W,
    parameter int D = `MPS_DEPTH
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         clr,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    logic [W-1:0]         mem [D];
    logic [$clog2(D)-1:0] wp;
    logic [$clog2(D)-1:0] rp;
    logic [$clog2(D):0]   cnt;
    logic [$clog2(D):0]   next_cnt;
    logic                 push;
    logic                 pop;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rp];
    assign next_cnt = cnt + ($clog2(D)+1)'(push) - ($clog2(D)+1)'(pop);
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end
    always_ff @(posedge clk) begin
        if (rst || clr) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            wp <= wp + $clog2(D)'(push);
            rp <= rp + $clog2(D)'(pop);
            cnt <= next_cnt;
            in_ready <= next_cnt != ($clog2(D)+1)'(D);
            out_valid <= next_cnt != '0;
        end
    end
endmodule

module mps_top
    import mps_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [1:0]  proto_sel,
    input  wire logic [1:0]  uart_variant,
    input  wire logic [1:0]  spi_variant,
    input  wire logic        i2c_master,
    input  wire logic        memory_mailbox_slave,
    input  wire logic        mp_mode,
    input  wire logic        parity_en,
    input  wire logic        parity_odd,
    input  wire logic [15:0] rate_div,
    input  wire logic [6:0]  own_addr,
    input  wire logic [6:0]  irq_enable,
    input  wire logic [6:0]  status_clr,
    output logic [6:0]       status,
    output logic             irq,
    input  wire logic [8:0]  tx_data,
    input  wire logic        tx_valid,
    output logic             tx_ready,
    output logic [8:0]       rx_data,
    output logic             rx_valid,
    input  wire logic        rx_ready,
    input  wire logic        uart_rx_pin,
    output logic             uart_tx_pin,
    input  wire logic        spi_sck_pin,
    input  wire logic        spi_mosi_pin,
    input  wire logic        spi_ss_n_pin,
    output logic             spi_miso_pin,
    output logic             spi_miso_oe_n,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe_n,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n
);
    function automatic logic [15:0] clampdiv(input logic [15:0] d,
                                             input logic [15:0] m);
        return (d < m) ? m : d;
    endfunction
    function automatic logic par(input logic [7:0] d, input logic odd);
        return (^d) ^ odd;
    endfunction

    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
    logic [1:0] proto_q;
    logic       chg;
    logic [8:0] txq_d;
    logic       txq_v;
    logic       txq_pop;
    logic [8:0] rxq_d;
    logic       rxq_v;
    logic       rxq_room;
    logic [6:0] ev;
    logic [6:0] next_status;

    // Pin synchronisers: rx, sck, mosi, ss_n, scl, sda
    always_ff @(posedge clk) begin
        s1 <= {uart_rx_pin, spi_sck_pin, spi_mosi_pin, spi_ss_n_pin,
               scl_in, sda_in};
        s2 <= s1;
        s3 <= s2;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            proto_q <= `MPS_P_UART;
        end else begin
            proto_q <= proto_sel;
        end
    end
    assign chg = proto_sel != proto_q;

    mps_fifo #(.W(`MPS_W), .D(`MPS_DEPTH)) u_txq (
        .clk       (clk),
        .rst       (rst),
        .clr       (chg),
        .in_data   (tx_data),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .out_data  (txq_d),
        .out_valid (txq_v),
        .out_ready (txq_pop)
    );
    mps_fifo #(.W(`MPS_W), .D(`MPS_DEPTH)) u_rxq (
        .clk       (clk),
        .rst       (rst),
        .clr       (chg),
        .in_data   (rxq_d),
        .in_valid  (rxq_v),
        .in_ready  (rxq_room),
        .out_data  (rx_data),
        .out_valid (rx_valid),
        .out_ready (rx_ready)
    );

    // UART
    logic        uon;
    logic        ninth;
    logic        irda;
    logic [15:0] ubd;
    logic [15:0] ilen;
    logic        utb;
    logic [15:0] utc;
    logic [3:0]  utn;
    logic [10:0] uts;
    logic        urb;
    logic [15:0] urc;
    logic [3:0]  urn;
    logic [10:0] urs;
    logic        usmp;
    logic        ulow;
    logic        ux;
    logic        ubit;
    logic        udone;
    logic        unak;
    logic [15:0] unc;
    logic        mpm;
    logic [7:0]  ud;
    logic        u_pe;
    logic        u_fe;
    logic        u_brk;
    logic        u_acc;
    logic        upop;
    assign uon = proto_q == `MPS_P_UART && !chg;
    assign ninth = mp_mode || parity_en;
    assign irda = uart_variant == `MPS_U_IRDA;
    assign ubd = clampdiv(rate_div, `MPS_UART_CYC);
    assign ilen = 16'(({2'b00, ubd} * `MPS_IR_NUM) >> `MPS_IR_SH);
    assign upop = uon && !utb && txq_v && !unak;
    assign ux = irda ? !s2[5] : s2[5];
    assign ubit = irda ? !(ulow || !ux) : usmp;
    assign ud = ninth ? urs[8:1] : urs[9:2];
    assign u_fe = !urs[10];
    assign u_brk = u_fe && ud == 8'h00 && !(ninth && urs[9]);
    assign u_pe = parity_en && !mp_mode && urs[9] != par(ud, parity_odd);
    assign u_acc = (!mp_mode || (urs[9] ? ud == {1'b0, own_addr} : mpm))
                   && !(uart_variant == `MPS_U_LIN && u_brk);

    always_ff @(posedge clk) begin
        if (rst || !uon) begin
            utb <= 1'b0;
            utc <= 16'h0000;
            utn <= 4'h0;
            uts <= '1;
        end else if (upop) begin
            utb <= 1'b1;
            utc <= ubd;
            utn <= ninth ? `MPS_UF_LONG : `MPS_UF_SHORT;
            uts <= ninth ? {1'b1, mp_mode ? txq_d[8]
                   : par(txq_d[7:0], parity_odd), txq_d[7:0], 1'b0}
                   : {2'b11, txq_d[7:0], 1'b0};
        end else if (utb && utc == 16'h0000) begin
            utc <= ubd;
            uts <= {1'b1, uts[10:1]};
            utn <= utn - 4'h1;
            utb <= utn != 4'h1;
        end else if (utb) begin
            utc <= utc - 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !uon) begin
            urb <= 1'b0;
            urc <= 16'h0000;
            urn <= 4'h0;
            urs <= '0;
            usmp <= 1'b1;
            ulow <= 1'b0;
            udone <= 1'b0;
            mpm <= 1'b0;
            unak <= 1'b0;
            unc <= 16'h0000;
        end else begin
            udone <= 1'b0;
            if (!urb && !ux) begin
                urb <= 1'b1;
                urc <= ubd;
                urn <= ninth ? `MPS_UF_LONG : `MPS_UF_SHORT;
                ulow <= 1'b0;
            end else if (urb && urc == 16'h0000) begin
                urc <= ubd;
                urs <= {ubit, urs[10:1]};
                urn <= urn - 4'h1;
                urb <= urn != 4'h1;
                udone <= urn == 4'h1;
                ulow <= 1'b0;
            end else if (urb) begin
                urc <= urc - 16'h0001;
                ulow <= ulow || !ux;
                if (urc == (ubd >> 1)) begin
                    usmp <= ux;
                end
            end
            if (udone && mp_mode && urs[9]) begin
                mpm <= ud == {1'b0, own_addr};
            end
            if (udone && u_pe && uart_variant == `MPS_U_SC) begin
                unak <= 1'b1;
                unc <= ubd;
            end else if (unak && unc == 16'h0000) begin
                unak <= 1'b0;
            end else if (unak) begin
                unc <= unc - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            uart_tx_pin <= 1'b1;
        end else if (unak) begin
            uart_tx_pin <= 1'b0;
        end else if (irda) begin
            uart_tx_pin <= utb && !uts[0] && utc > ubd - ilen;
        end else begin
            uart_tx_pin <= !utb || uts[0];
        end
    end

    // SPI slave
    logic       son;
    logic       framed;
    logic       half;
    logic       sr;
    logic       sf;
    logic       sact;
    logic       sdir;
    logic [3:0] sn;
    logic [7:0] srx;
    logic [7:0] stx;
    logic       sstart;
    logic       sbyte;
    logic       spop;
    assign son = proto_q == `MPS_P_SPI && !chg;
    assign framed = spi_variant == `MPS_S_FRAMED;
    assign half = spi_variant == `MPS_S_HALF;
    assign sr = s2[4] && !s3[4];
    assign sf = !s2[4] && s3[4];
    assign sstart = !sact && (framed ? sr && s2[2] : !s2[2]);
    assign sbyte = sact && sr && sn == `MPS_LAST_BIT;
    assign spop = son && txq_v && (sstart || (sbyte && !framed));

    always_ff @(posedge clk) begin
        if (rst || !son) begin
            sact <= 1'b0;
            sdir <= 1'b0;
            sn <= 4'h0;
            srx <= 8'h00;
            stx <= `MPS_FILL;
            spi_miso_pin <= 1'b1;
            spi_miso_oe_n <= 1'b1;
        end else begin
            if (!framed && s2[2]) begin
                sact <= 1'b0;
            end else if (sstart || (sbyte && !framed)) begin
                sact <= 1'b1;
                sn <= 4'h0;
                sdir <= txq_v;
                stx <= txq_v ? txq_d[7:0] : `MPS_FILL;
                if (sstart) begin
                    spi_miso_pin <= txq_v ? txq_d[7] : 1'b1;
                end
            end else if (sact && sr) begin
                sn <= sn + 4'h1;
                stx <= {stx[6:0], 1'b1};
                sact <= !sbyte;
            end
            if (sact && sr) begin
                srx <= {srx[6:0], s2[3]};
            end
            if (sact && sf) begin
                spi_miso_pin <= stx[7];
            end
            spi_miso_oe_n <= !((sact || sstart) && !(half && !sdir));
        end
    end

    // I2C master
    logic        ion;
    logic        mon;
    mps_m_e      ms;
    logic [1:0]  mq;
    logic [15:0] mt;
    logic [15:0] iqd;
    logic [3:0]  mb;
    logic [7:0]  msh;
    logic        msc;
    logic        msd;
    logic        mrd;
    logic        mbr;
    logic        mfirst;
    logic        mlast;
    logic        mpend;
    logic        mlost;
    logic        mdone;
    logic        mpop;
    logic        mpush;
    assign ion = proto_q == `MPS_P_I2C && !chg;
    assign mon = ion && i2c_master;
    assign iqd = clampdiv(rate_div, `MPS_I2C_QCYC);
    assign mpush = mon && mt == 16'h0000 && ms == m_next && mpend
                   && rxq_room;
    assign mpop = mon && mt == 16'h0000 && ms == m_next && !mpend
                  && !mlast && txq_v;

    always_ff @(posedge clk) begin
        if (rst || !mon) begin
            ms <= m_idle;
            mq <= 2'h0;
            mt <= 16'h0000;
            mb <= 4'h0;
            msh <= `MPS_FILL;
            {msc, msd, mrd, mbr, mfirst, mlast, mpend} <= 7'h62;
            {mlost, mdone} <= 2'h0;
        end else begin
            {mlost, mdone} <= 2'h0;
            if (mt != 16'h0000) begin
                mt <= mt - 16'h0001;
            end else begin
                case (ms)
                m_idle: if (txq_v && s2[1] && s2[0]) begin
                    ms <= m_start;
                    msd <= 1'b0;
                    mt <= iqd;
                    mfirst <= 1'b1;
                    mlast <= 1'b0;
                end
                m_start: begin
                    msc <= 1'b0;
                    ms <= m_next;
                    mt <= iqd;
                end
                m_next: if (mpend) begin
                    mpend <= !rxq_room;
                end else if (mlast) begin
                    ms <= m_stop;
                    mq <= 2'h0;
                end else if (txq_v) begin
                    ms <= m_bit;
                    mq <= 2'h0;
                    mb <= 4'h0;
                    mbr <= mrd && !mfirst;
                    msh <= (mrd && !mfirst) ? `MPS_FILL : txq_d[7:0];
                    mlast <= txq_d[8];
                    mfirst <= 1'b0;
                    if (mfirst) begin
                        mrd <= txq_d[0];
                    end
                end
                m_bit: begin
                    mq <= mq + 2'h1;
                    mt <= iqd;
                    case (mq)
                    2'h0: msd <= (mb == `MPS_ACK_BIT) ? (!mbr || mlast)
                                 : (mbr || msh[7]);
                    2'h1: msc <= 1'b1;
                    2'h2: if (!s2[1]) begin
                        mq <= mq;
                    end else if (msd && !s2[0] && !mbr
                                 && mb != `MPS_ACK_BIT) begin
                        ms <= m_idle;
                        {msc, msd} <= 2'h3;
                        mlost <= 1'b1;
                    end else if (mb != `MPS_ACK_BIT) begin
                        msh <= {msh[6:0], s2[0]};
                    end else if (!mbr && s2[0]) begin
                        mlast <= 1'b1;
                    end
                    default: begin
                        msc <= 1'b0;
                        mb <= mb + 4'h1;
                        if (mb == `MPS_ACK_BIT) begin
                            ms <= m_next;
                            mpend <= mbr;
                        end
                    end
                    endcase
                end
                m_stop: begin
                    mq <= mq + 2'h1;
                    mt <= iqd;
                    case (mq)
                    2'h0: msd <= 1'b0;
                    2'h1: msc <= 1'b1;
                    default: begin
                        msd <= 1'b1;
                        ms <= m_idle;
                        mdone <= 1'b1;
                    end
                    endcase
                end
                default: ms <= m_idle;
                endcase
            end
        end
    end

    // I2C slave with optional mailbox
    logic [7:0] mbx [`MPS_MBX_WORDS];
    logic       slon;
    logic       sc_r;
    logic       sc_f;
    logic       sa;
    logic       sadr;
    logic       srw;
    logic       sfirst;
    logic       sdl;
    logic       sstr;
    logic [3:0] sbn;
    logic [7:0] ssh;
    logic [7:0] sst;
    logic [3:0] sptr;
    logic       snext;
    logic       slpop;
    logic       slpush;
    assign slon = ion && !i2c_master;
    assign sc_r = s2[1] && !s3[1];
    assign sc_f = !s2[1] && s3[1];
    assign snext = sc_f && sbn == `MPS_ACK_BIT && srw;
    assign slpop = slon && sa && srw && !memory_mailbox_slave && txq_v
                   && (sstr || snext);
    assign slpush = slon && sa && !srw && !sadr && !memory_mailbox_slave
                    && rxq_room && (sstr || (sc_f && sbn == `MPS_LAST_BIT));

    always_ff @(posedge clk) begin
        if (rst || !slon) begin
            {sa, sadr, srw, sfirst, sdl, sstr} <= 6'h00;
            sbn <= 4'h0;
            ssh <= 8'h00;
            sst <= `MPS_FILL;
            sptr <= 4'h0;
        end else if (s2[1] && !s2[0] && s3[0]) begin
            {sa, sadr, sfirst, sdl, sstr} <= 5'h1c;
            sbn <= 4'h0;
        end else if (s2[1] && s2[0] && !s3[0]) begin
            {sa, sdl, sstr} <= 3'h0;
        end else if (sa && sstr) begin
            if (slpush) begin
                {sstr, sdl} <= 2'h1;
            end else if (slpop) begin
                sstr <= 1'b0;
                sst <= {txq_d[6:0], 1'b1};
                sdl <= !txq_d[7];
            end
        end else if (sa && sc_r) begin
            if (sbn != `MPS_ACK_BIT) begin
                ssh <= {ssh[6:0], s2[0]};
            end else if (srw && s2[0]) begin
                {sa, sdl} <= 2'h0;
            end
        end else if (sa && sc_f) begin
            sbn <= (sbn == `MPS_ACK_BIT) ? 4'h0 : sbn + 4'h1;
            if (sbn == `MPS_LAST_BIT) begin
                sdl <= 1'b0;
                if (sadr) begin
                    sadr <= 1'b0;
                    sa <= ssh[7:1] == own_addr;
                    sdl <= ssh[7:1] == own_addr;
                    srw <= ssh[0];
                end else if (!srw && memory_mailbox_slave) begin
                    sdl <= 1'b1;
                    sfirst <= 1'b0;
                    sptr <= sfirst ? ssh[3:0] : sptr + 4'h1;
                    if (!sfirst) begin
                        mbx[sptr] <= ssh;
                    end
                end else if (!srw) begin
                    sdl <= slpush;
                    sstr <= !slpush;
                end
            end else if (snext && memory_mailbox_slave) begin
                sst <= {mbx[sptr][6:0], 1'b1};
                sdl <= !mbx[sptr][7];
                sptr <= sptr + 4'h1;
            end else if (snext) begin
                sst <= {txq_d[6:0], 1'b1};
                sdl <= txq_v && !txq_d[7];
                sstr <= !txq_v;
            end else if (sbn == `MPS_ACK_BIT) begin
                sdl <= 1'b0;
            end else if (srw) begin
                sdl <= !sst[7];
                sst <= {sst[6:0], 1'b1};
            end
        end
    end

    // Shared FIFO ports and open-drain drive
    assign txq_pop = upop || spop || mpop || slpop;
    assign rxq_v = (uon && udone && u_acc) || (son && sbyte
                   && !(half && sdir)) || mpush || slpush;
    always_comb begin
        rxq_d = {1'b0, ssh};
        if (uon) begin
            rxq_d = {mp_mode && urs[9], ud};
        end else if (son) begin
            rxq_d = {1'b0, srx[6:0], s2[3]};
        end else if (mon) begin
            rxq_d = {1'b0, msh};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            scl_oe_n <= 1'b1;
            sda_oe_n <= 1'b1;
        end else begin
            scl_oe_n <= !(ion && (i2c_master ? !msc : sstr));
            sda_oe_n <= !(ion && (i2c_master ? !msd : sdl));
        end
    end

    // Sticky events gated by enables
    assign ev = {mdone || (uon && utb && utn == 4'h1 && utc == 16'h0000)
                 || (son && sbyte), mlost, uon && udone && u_brk,
                 uon && udone && u_fe, uon && udone && u_pe,
                 !txq_v, rxq_v};
    assign next_status = (status & ~status_clr) | ev;
    always_ff @(posedge clk) begin
        if (rst) begin
            status <= 7'h00;
            irq <= 1'b0;
        end else begin
            status <= next_status;
            irq <= |(next_status & irq_enable);
        end
    end
endmodule

/* test/mps_top_sva.sv */
// Port assertions for the serial block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module mps_top_sva (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [1:0] proto_sel,
    input wire logic [6:0] irq_enable,
    input wire logic [6:0] status_clr,
    input wire logic [6:0] status,
    input wire logic       irq,
    input wire logic [8:0] rx_data,
    input wire logic       rx_valid,
    input wire logic       rx_ready,
    input wire logic       spi_miso_oe_n,
    input wire logic       scl_out,
    input wire logic       scl_oe_n,
    input wire logic       sda_out,
    input wire logic       sda_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_irq_gated: assert property (
        (status & $past(irq_enable)) == 7'h00 |-> !irq)
        else $error("stray irq");
    a_lines_low_only: assert property (!scl_out && !sda_out)
        else $error("line driven high");
    a_i2c_released: assert property (
        proto_sel != 2'h2 && $past(proto_sel) != 2'h2 |-> scl_oe_n && sda_oe_n)
        else $error("i2c lines held");
    a_miso_released: assert property (
        proto_sel != 2'h1 && $past(proto_sel) != 2'h1 |-> spi_miso_oe_n)
        else $error("miso driven");
    a_rx_holds: assert property (
        $stable(proto_sel) && rx_valid && !rx_ready ##1 $stable(proto_sel)
        |-> rx_valid && $stable(rx_data)) else $error("rx word lost");
    a_err_sticky: assert property (
        (~status[4:2] & $past(status[4:2]) & ~$past(status_clr[4:2])) == 0)
        else $error("error flag lost");
    a_rx_flag: assert property ($rose(rx_valid) |-> ##[0:2] status[0])
        else $error("no rx flag");
    a_fifo_clear: assert property (
        $changed(proto_sel) |-> ##[0:2] !rx_valid) else $error("fifo kept");
endmodule
bind mps_top mps_top_sva mps_top_sva_i (.*);

/* test/mps_uart_peer.sv */
// Remote UART station on the far side of the serial pins.
// Assumes the bench keeps BIT_NS equal to the block's bit time.
`timescale 1ns/10ps
module mps_uart_peer #(
    parameter int BIT_NS = 1100
) (
    output logic      line_out,
    input  wire logic line_in
);
    initial line_out = 1'b1;
    // Start, eight data bits LSB first, optional ninth bit, stop level
    task automatic send(input logic [8:0] d, input logic nine, stp);
        line_out = 1'b0;
        #(BIT_NS);
        for (int i = 0; i < 9; i++) begin
            if (i < 8 || nine) begin
                line_out = d[i];
                #(BIT_NS);
            end
        end
        line_out = stp;
        #(BIT_NS);
        line_out = 1'b1;
        #(2 * BIT_NS);
    endtask
    task automatic recv(output logic [7:0] d);
        @(negedge line_in);
        #(BIT_NS * 3 / 2);
        for (int i = 0; i < 8; i++) begin
            d[i] = line_in;
            #(BIT_NS);
        end
    endtask
endmodule

/* test/mps_top_tb.sv */
// Self-checking bench for the serial block in UART and SPI operation.
// Assumes a 10 MHz clock and an 11-cycle bit time.
`timescale 1ns/10ps
module mps_top_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [1:0]  proto_sel, uart_variant, spi_variant;
    logic        i2c_master, memory_mailbox_slave, mp_mode, parity_en;
    logic        parity_odd, tx_valid, tx_ready, rx_valid, rx_ready, irq;
    logic [15:0] rate_div;
    logic [6:0]  own_addr, irq_enable, status_clr, status;
    logic [8:0]  tx_data, rx_data;
    logic        uart_tx_pin, spi_sck_pin, spi_mosi_pin, spi_ss_n_pin;
    logic        spi_miso_pin, spi_miso_oe_n, scl_out, scl_oe_n, sda_out;
    logic        sda_oe_n;
    wire logic   uart_rx_pin, scl_in, sda_in;
    logic [7:0]  q[$];
    logic [7:0]  d, b;
    int          fail_count = 0, checks_done = 0, cyc = 0, k;
    assign scl_in = scl_oe_n;
    assign sda_in = sda_oe_n;
    always #50 clk = ~clk;
    mps_top mps_top_i (.*);
    mps_uart_peer #(.BIT_NS(1100)) mps_uart_peer_i (
        .line_out(uart_rx_pin),
        .line_in (uart_tx_pin)
    );
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string s, input logic [8:0] e, g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic end_sim;
        if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end
    initial begin
        void'($urandom(30608));
        {proto_sel, uart_variant, spi_variant, i2c_master} = 7'h00;
        {memory_mailbox_slave, mp_mode, parity_en, parity_odd} = 4'h0;
        {tx_valid, rx_ready, spi_sck_pin, spi_mosi_pin} = 4'h0;
        {spi_ss_n_pin, rate_div, own_addr, tx_data} = 33'h1_000a_0000;
        {irq_enable, status_clr} = 14'h0000;
        step(6);
        rst = 1'b0;
        step(2);
        // Fill the transmit FIFO until refused while the peer reads frames
        tx_valid = 1'b1;
        fork
            begin
                for (k = 0; k < 20 && tx_ready; k++) begin
                    tx_data = {1'b0, 8'($urandom)};
                    q.push_back(tx_data[7:0]);
                    step(1);
                end
                tx_valid = 1'b0;
                chk("tx depth", 9'h001, {8'h00, k >= 8});
            end
            while (q.size() > 0 || tx_valid) begin
                mps_uart_peer_i.recv(b);
                chk("tx frame", {1'b0, q.pop_front()}, {1'b0, b});
            end
        join
        // Overrun the stalled receive FIFO by one word, then drain it
        for (k = 0; k < 9; k++) begin
            d = 8'($urandom);
            if (k < 8) q.push_back(d);
            mps_uart_peer_i.send({1'b0, d}, 1'b0, 1'b1);
        end
        for (k = 0; k < 8; k++) begin
            chk("rx word", {1'b0, q.pop_front()}, rx_data);
            rx_ready = 1'b1;
            step(1);
            rx_ready = 1'b0;
            step(1);
        end
        chk("rx empty", 9'h000, {8'h00, rx_valid});
        mps_uart_peer_i.send(9'h0a5, 1'b0, 1'b1);
        proto_sel = 2'h1;
        step(1);
        proto_sel = 2'h0;
        step(3);
        chk("rx cleared", 9'h000, {8'h00, rx_valid});
        // Parity error, framing error, then break
        for (k = 2; k < 5; k++) begin
            d = (k == 4) ? 8'h00 : 8'($urandom) | 8'h01;
            parity_en = (k != 4);
            parity_odd = 1'($urandom);
            status_clr = 7'h7f;
            step(1);
            status_clr = 7'h00;
            mps_uart_peer_i.send({^d ^ parity_odd ^ (k == 2), d},
                                 parity_en, k == 2);
            chk("error flag", 9'h001, {8'h00, status[k]});
        end
        irq_enable = 7'h10;
        step(2);
        chk("irq raised", 9'h001, {8'h00, irq});
        status_clr = 7'h10;
        step(2);
        chk("irq cleared", 9'h000, {8'h00, irq});
        // Four-wire SPI, mode 0: one byte each way, MSB first, 800 ns sck
        proto_sel = 2'h1;
        tx_data = {1'b0, 8'($urandom)};
        d = 8'($urandom);
        step(2);
        tx_valid = 1'b1;
        step(1);
        tx_valid = 1'b0;
        spi_ss_n_pin = 1'b0;
        for (k = 7; k >= 0; k--) begin
            spi_mosi_pin = d[k];
            step(4);
            spi_sck_pin = 1'b1;
            b[k] = spi_miso_pin;
            step(4);
            spi_sck_pin = 1'b0;
        end
        spi_ss_n_pin = 1'b1;
        step(4);
        chk("spi miso", {1'b0, tx_data[7:0]}, {1'b0, b});
        chk("spi mosi", {1'b0, d}, rx_data);
        end_sim();
    end
endmodule
